// ==== hdl/pse_i2c_slave.sv ====
// Two-wire serial slave that turns bus frames into register byte strobes
`timescale 1ns/1ps
module pse_i2c_slave
    import pse_pkg::*;
(
    input logic core_clk,
    input logic reset_n,
    input logic clkEn,
    input logic powerOnDone,
    input logic sclIn,
    input logic sdaIn,
    output logic sdaOe,
    pse_reg_if.link bus
);
    typedef enum {ST_IDLE, ST_DEV, ST_DEVACK, ST_REG, ST_REGACK, ST_WR, ST_WRACK,
        ST_RD, ST_RDACK, ST_RDLOAD} pse_i2c_e;

    pse_i2c_e state_r;
    logic [1:0] sclSync_r;
    logic [1:0] sdaSync_r;
    logic sclLast_r;
    logic sdaLast_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic ackOn_r;
    logic sclHi;
    logic sdaHi;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] byteIn;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclLast_r <= 1'b1;
            sdaLast_r <= 1'b1;
        end
        else if (clkEn)
        begin
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclLast_r <= sclSync_r[1];
            sdaLast_r <= sdaSync_r[1];
        end
    end

    assign sclHi = sclSync_r[1];
    assign sdaHi = sdaSync_r[1];
    assign sclRise = sclHi & ~sclLast_r;
    assign sclFall = ~sclHi & sclLast_r;
    assign startSeen = sclHi & sclLast_r & sdaLast_r & ~sdaHi;
    assign stopSeen = sclHi & sclLast_r & ~sdaLast_r & sdaHi;
    assign byteIn = {shift_r[6:0], sdaHi};

    // Data moves only on the falling clock, so the host sees it settled at the rise
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            ackOn_r <= 1'b0;
            sdaOe <= 1'b0;
            bus.addrStb <= 1'b0;
            bus.wrStb <= 1'b0;
            bus.rdAdv <= 1'b0;
            bus.dataByte <= 8'h00;
        end
        else if (clkEn)
        begin
            bus.addrStb <= 1'b0;
            bus.wrStb <= 1'b0;
            bus.rdAdv <= 1'b0;
            if (stopSeen)
            begin
                state_r <= ST_IDLE;
                sdaOe <= 1'b0;
                ackOn_r <= 1'b0;
            end
            else if (startSeen)
            begin
                state_r <= ST_DEV;
                bitCnt_r <= 3'h0;
                sdaOe <= 1'b0;
                ackOn_r <= 1'b0;
            end
            else if (sclRise)
            begin
                case (state_r)
                    ST_DEV, ST_REG, ST_WR:
                    begin
                        shift_r <= byteIn;
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                        begin
                            case (state_r)
                                ST_DEV:
                                begin
                                    // Unpowered device leaves its address unanswered
                                    if (byteIn[7:1] == PSE_DEV_ADDR && powerOnDone) // RULE_10
                                    begin
                                        state_r <= ST_DEVACK;
                                        rw_r <= byteIn[0];
                                    end
                                    else
                                    begin
                                        state_r <= ST_IDLE;
                                    end
                                end
                                ST_REG:
                                begin
                                    state_r <= ST_REGACK;
                                    bus.addrStb <= 1'b1;
                                    bus.dataByte <= byteIn;
                                end
                                default:
                                begin
                                    state_r <= ST_WRACK;
                                    bus.wrStb <= 1'b1;
                                    bus.dataByte <= byteIn;
                                end
                            endcase
                        end
                    end
                    ST_RD:
                    begin
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                        begin
                            state_r <= ST_RDACK;
                        end
                    end
                    ST_RDACK:
                    begin
                        if (!sdaHi)
                        begin
                            bus.rdAdv <= 1'b1;
                            state_r <= ST_RDLOAD;
                        end
                        else
                        begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (sclFall)
            begin
                case (state_r)
                    ST_DEVACK, ST_REGACK, ST_WRACK:
                    begin
                        if (!ackOn_r)
                        begin
                            sdaOe <= 1'b1;
                            ackOn_r <= 1'b1;
                        end
                        else
                        begin
                            ackOn_r <= 1'b0;
                            bitCnt_r <= 3'h0;
                            if (state_r == ST_DEVACK && rw_r)
                            begin
                                shift_r <= bus.rdByte;
                                sdaOe <= ~bus.rdByte[7];
                                state_r <= ST_RD;
                            end
                            else
                            begin
                                sdaOe <= 1'b0;
                                state_r <= (state_r == ST_DEVACK) ? ST_REG : ST_WR;
                            end
                        end
                    end
                    ST_RD:
                    begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sdaOe <= ~shift_r[6];
                    end
                    ST_RDACK:
                    begin
                        sdaOe <= 1'b0;
                    end
                    ST_RDLOAD:
                    begin
                        shift_r <= bus.rdByte;
                        sdaOe <= ~bus.rdByte[7];
                        bitCnt_r <= 3'h0;
                        state_r <= ST_RD;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_no_early_ack: assert property ((state_r == ST_DEVACK) |-> powerOnDone) // RULE_10
        else $error("Address acknowledged before power-on completed");
    cov_read_byte: cover property (bus.rdAdv);
endmodule

// ==== hdl/pse_pkg.sv ====
// Constants and register layout of the PMU status and enable register bank
// Functional notes
// RULE_01 - Thermal shutdown flag sticks until written zero
// RULE_02 - LED mode bit: 0 current source, 1 boost
// RULE_03 - Ratio select: 0 gives 60/28%, 1 74/28%
// RULE_04 - Eight protection flags latch until software clears
// RULE_05 - Channel five, six, eight enables: 1 on
// RULE_06 - LED code zero turns LED driver off
// RULE_07 - Nonzero LED code: driver on, reference code/31*0.25V
// RULE_08 - Enable register layout 7,6,5 and code 4:0
// RULE_09 - Protection register flag one bit7 to eight bit0
// RULE_10 - Serial accesses accepted only after power-on completes
// RULE_11 - Event beats clear; writing one never sets
package pse_pkg;
    localparam logic [7:0] PSE_OFS_CTRL = 8'h00;
    localparam logic [7:0] PSE_OFS_PROT = 8'h01;
    localparam logic [7:0] PSE_OFS_CHAN = 8'h02;
    localparam int PSE_BIT_THERM = 2;
    localparam int PSE_BIT_MODE = 1;
    localparam int PSE_BIT_RATIO = 0;
    localparam int PSE_BIT_STEP5 = 7;
    localparam int PSE_BIT_LDO6 = 6;
    localparam int PSE_BIT_LDO8 = 5;
    localparam int PSE_CODE_MSB = 4;
    localparam logic PSE_RST_THERM = 1'b0;
    localparam logic PSE_RST_RATIO = 1'b1;
    localparam logic [7:0] PSE_RST_PROT = 8'h00;
    localparam logic [7:0] PSE_RST_CHAN = 8'h00;
    localparam logic [7:0] PSE_RD_UNMAPPED = 8'h00;
    // Arbitrary default bus address
    localparam logic [6:0] PSE_DEV_ADDR = 7'h2a;
endpackage

// ==== hdl/pse_reg_if.sv ====
// Byte strobes between the serial slave and the register bank
`timescale 1ns/1ps
interface pse_reg_if;
    logic addrStb;
    logic wrStb;
    logic rdAdv;
    logic [7:0] dataByte;
    logic [7:0] rdByte;
    modport link
    (
        output addrStb,
        output wrStb,
        output rdAdv,
        output dataByte,
        input rdByte
    );
    modport bank
    (
        input addrStb,
        input wrStb,
        input rdAdv,
        input dataByte,
        output rdByte
    );
endinterface

// ==== hdl/pse_status_enable_regs.sv ====
// PMU status flags, channel enables and LED dimming code behind the serial slave
`timescale 1ns/1ps
module pse_status_enable_regs
    import pse_pkg::*;
(
    input logic core_clk,
    input logic reset_n,
    input logic clkEn,
    input logic powerOnDone,
    input logic sclIn,
    input logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input logic thermalShutdownEvent,
    input logic ledModeDetect,
    input logic [7:0] protectionEvent,
    output logic battTempRatioSelect,
    output logic stepDownFiveEnable,
    output logic ldoSixEnable,
    output logic ldoEightEnable,
    output logic whiteLedDriverOn,
    output logic [4:0] ledFeedbackReference
);
    import pse_pkg::*;

    pse_reg_if regBus ();

    logic [1:0] thermSync_r;
    logic [1:0] modeSync_r;
    logic [7:0] protSync0_r;
    logic [7:0] protSync1_r;
    logic [7:0] ptr_r;
    logic thermFlag_r;
    logic thermFlag_nxt;
    logic ratio_r;
    logic [7:0] protFlags_r;
    logic [7:0] protFlags_nxt;
    logic [7:0] chan_r;
    logic ledOn_r;
    logic wrCtrl;
    logic wrProt;
    logic wrChan;

    function automatic logic [7:0] readMux(input logic [7:0] ofs, input logic therm,
        input logic mode, input logic ratio, input logic [7:0] prot, input logic [7:0] chan);
        logic [7:0] val;
        val = PSE_RD_UNMAPPED;
        case (ofs)
            PSE_OFS_CTRL:
            begin
                val[PSE_BIT_THERM] = therm;
                val[PSE_BIT_MODE] = mode;
                val[PSE_BIT_RATIO] = ratio;
            end
            PSE_OFS_PROT: val = prot;
            PSE_OFS_CHAN: val = chan;
            default: val = PSE_RD_UNMAPPED;
        endcase
        return val;
    endfunction

    pse_i2c_slave u_slave
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .powerOnDone(powerOnDone),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .bus(regBus.link)
    );

    // Open drain: only ever pulls low
    assign sdaOut = 1'b0;

    // Analog event lines are asynchronous to the core clock
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            thermSync_r <= 2'h0;
            modeSync_r <= 2'h0;
            protSync0_r <= 8'h00;
            protSync1_r <= 8'h00;
        end
        else if (clkEn)
        begin
            thermSync_r <= {thermSync_r[0], thermalShutdownEvent};
            modeSync_r <= {modeSync_r[0], ledModeDetect};
            protSync0_r <= protectionEvent;
            protSync1_r <= protSync0_r;
        end
    end

    // Auto-increment lets a host stream all three registers in one frame
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ptr_r <= 8'h00;
        end
        else if (clkEn)
        begin
            if (regBus.addrStb)
            begin
                ptr_r <= regBus.dataByte;
            end
            else if (regBus.wrStb || regBus.rdAdv)
            begin
                ptr_r <= ptr_r + 8'h01;
            end
        end
    end

    assign wrCtrl = regBus.wrStb && ptr_r == PSE_OFS_CTRL;
    assign wrProt = regBus.wrStb && ptr_r == PSE_OFS_PROT;
    assign wrChan = regBus.wrStb && ptr_r == PSE_OFS_CHAN;

    // A written zero clears, a written one is ignored, and a live event wins
    assign thermFlag_nxt = (thermFlag_r & ~(wrCtrl & ~regBus.dataByte[PSE_BIT_THERM]))
        | thermSync_r[1]; // RULE_01 RULE_11
    assign protFlags_nxt = (protFlags_r & ~({8{wrProt}} & ~regBus.dataByte))
        | protSync1_r; // RULE_04 RULE_09 RULE_11

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            thermFlag_r <= PSE_RST_THERM;
            protFlags_r <= PSE_RST_PROT;
        end
        else if (clkEn)
        begin
            thermFlag_r <= thermFlag_nxt;
            protFlags_r <= protFlags_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ratio_r <= PSE_RST_RATIO;
        end
        else if (clkEn && wrCtrl)
        begin
            ratio_r <= regBus.dataByte[PSE_BIT_RATIO]; // RULE_03
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_r <= PSE_RST_CHAN;
            ledOn_r <= 1'b0;
        end
        else if (clkEn && wrChan)
        begin
            chan_r <= regBus.dataByte; // RULE_08
            ledOn_r <= |regBus.dataByte[PSE_CODE_MSB:0]; // RULE_06 RULE_07
        end
    end

    assign regBus.rdByte = readMux(ptr_r, thermFlag_r, modeSync_r[1], ratio_r, protFlags_r,
        chan_r); // RULE_02
    assign battTempRatioSelect = ratio_r; // RULE_03
    assign stepDownFiveEnable = chan_r[PSE_BIT_STEP5]; // RULE_05
    assign ldoSixEnable = chan_r[PSE_BIT_LDO6]; // RULE_05
    assign ldoEightEnable = chan_r[PSE_BIT_LDO8]; // RULE_05
    assign whiteLedDriverOn = ledOn_r;
    // Reference DAC scales code/31 of its full scale
    assign ledFeedbackReference = chan_r[PSE_CODE_MSB:0]; // RULE_07

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_therm_sets: assert property (clkEn && thermSync_r[1] |=> thermFlag_r) // RULE_01
        else $error("Thermal event did not set its flag");
    chk_therm_holds: assert property (thermFlag_r && !wrCtrl |=> thermFlag_r) // RULE_01
        else $error("Thermal flag dropped without a clear");
    chk_mode_readback: assert property (ptr_r == PSE_OFS_CTRL // RULE_02
        |-> regBus.rdByte[PSE_BIT_MODE] == modeSync_r[1])
        else $error("Mode result not shown on readback");
    chk_ratio_write: assert property (clkEn && wrCtrl // RULE_03
        |=> battTempRatioSelect == $past(regBus.dataByte[PSE_BIT_RATIO]))
        else $error("Ratio select did not follow write");
    chk_prot_latch: assert property (clkEn // RULE_04
        |=> (protFlags_r & $past(protSync1_r)) == $past(protSync1_r))
        else $error("Protection event not latched");
    chk_enables_write: assert property (clkEn && wrChan // RULE_05
        |=> {stepDownFiveEnable, ldoSixEnable, ldoEightEnable} == $past(regBus.dataByte[7:5]))
        else $error("Channel enables did not follow write");
    chk_led_off: assert property (ledFeedbackReference == 5'h00 |-> !whiteLedDriverOn) // RULE_06
        else $error("LED driver on with zero code");
    chk_led_on: assert property (ledFeedbackReference != 5'h00 |-> whiteLedDriverOn) // RULE_07
        else $error("LED driver off with nonzero code");
    chk_chan_layout: assert property (ptr_r == PSE_OFS_CHAN // RULE_08
        |-> regBus.rdByte == {stepDownFiveEnable, ldoSixEnable, ldoEightEnable,
        ledFeedbackReference})
        else $error("Enable register readback mismatch");
    chk_prot_clear: assert property (clkEn && wrProt // RULE_09
        |=> protFlags_r == (($past(protFlags_r) & $past(regBus.dataByte)) | $past(protSync1_r)))
        else $error("Protection clear wrong");
    chk_set_wins: assert property (clkEn && wrCtrl && thermSync_r[1] // RULE_11
        && !regBus.dataByte[PSE_BIT_THERM] |=> thermFlag_r)
        else $error("Clear beat a simultaneous event");

    cov_therm_set: cover property (!thermFlag_r ##1 thermFlag_r);
    cov_chan_write: cover property (clkEn && wrChan);
    cov_prot_clear: cover property (clkEn && wrProt && protFlags_r != 8'h00);
endmodule

// ==== testbench/pse_i2c_host.sv ====
// Two-wire bus host model that issues register frames
`timescale 1ns/1ps
module pse_i2c_host
(
    input wire logic core_clk,
    input wire logic sdaWire,
    output logic sclOut,
    output logic sdaLow
);
    // Bench may shorten this for a fast host; keep above four cycles
    int halfCycles = 8;
    initial
    begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Data moves two cycles after SCL falls, never in the same cycle
    task automatic put_bit(input logic b, output logic rd);
        pause(2);
        sdaLow = ~b;
        pause(halfCycles);
        sclOut = 1'b1;
        pause(halfCycles / 2);
        rd = sdaWire;
        pause(halfCycles - halfCycles / 2);
        sclOut = 1'b0;
    endtask
    // Serves as repeated start too
    task automatic start_cond();
        pause(2);
        sdaLow = 1'b0;
        pause(halfCycles);
        sclOut = 1'b1;
        pause(halfCycles);
        sdaLow = 1'b1;
        pause(halfCycles);
        sclOut = 1'b0;
    endtask
    task automatic stop_cond();
        pause(2);
        sdaLow = 1'b1;
        pause(halfCycles);
        sclOut = 1'b1;
        pause(halfCycles);
        sdaLow = 1'b0;
        pause(halfCycles);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic rd;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], rd);
        put_bit(1'b1, rd);
        ack = ~rd;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic rd;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, rd);
            d[i] = rd;
        end
        put_bit(last, rd);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] d, output logic ok);
        logic ackDev, ackOfs, ackDat;
        start_cond();
        send_byte({dev, 1'b0}, ackDev);
        send_byte(ofs, ackOfs);
        send_byte(d, ackDat);
        stop_cond();
        ok = ackDev & ackOfs & ackDat;
    endtask
    // Two data bytes in one frame exercise the pointer auto-increment
    task automatic write_pair(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] d0, input logic [7:0] d1, output logic ok);
        logic ackDev, ackOfs, ackFirst, ackSecond;
        start_cond();
        send_byte({dev, 1'b0}, ackDev);
        send_byte(ofs, ackOfs);
        send_byte(d0, ackFirst);
        send_byte(d1, ackSecond);
        stop_cond();
        ok = ackDev & ackOfs & ackFirst & ackSecond;
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
        output logic [7:0] d, output logic ok);
        logic ackDev, ackOfs, ackRd;
        start_cond();
        send_byte({dev, 1'b0}, ackDev);
        send_byte(ofs, ackOfs);
        start_cond();
        send_byte({dev, 1'b1}, ackRd);
        recv_byte(1'b1, d);
        stop_cond();
        ok = ackDev & ackOfs & ackRd;
    endtask
    // Host acknowledges the first byte so the slave streams the next register
    task automatic read_pair(input logic [6:0] dev, input logic [7:0] ofs,
        output logic [7:0] d0, output logic [7:0] d1, output logic ok);
        logic ackDev, ackOfs, ackRd;
        start_cond();
        send_byte({dev, 1'b0}, ackDev);
        send_byte(ofs, ackOfs);
        start_cond();
        send_byte({dev, 1'b1}, ackRd);
        recv_byte(1'b0, d0);
        recv_byte(1'b1, d1);
        stop_cond();
        ok = ackDev & ackOfs & ackRd;
    endtask
endmodule

// ==== testbench/pse_status_enable_regs_tb.sv ====
// Self-checking bench for the PMU status and enable register bank
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module pse_status_enable_regs_tb;
    import pse_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n, clkEn, powerOnDone, sclIn, sdaIn, sdaOut, sdaOe;
    logic thermalShutdownEvent, ledModeDetect, battTempRatioSelect;
    logic stepDownFiveEnable, ldoSixEnable, ldoEightEnable, whiteLedDriverOn;
    logic [7:0] protectionEvent;
    logic [4:0] ledFeedbackReference;
    logic hostScl, hostSdaLow, ok;
    logic [7:0] v, p, c;
    int err_total = 0;
    int tests_run = 0;
    int cycleCount = 0;
    int unsigned seedTmp;
    logic [7:0] corner[8] = '{8'h01, 8'h1f, 8'he0, 8'h80, 8'h40, 8'h20, 8'hff, 8'h00};
    // Open-drain data wire with pull-up
    assign sdaIn = ~(hostSdaLow | sdaOe);
    assign sclIn = hostScl;
    pse_status_enable_regs i_dut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
        .powerOnDone(powerOnDone), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .thermalShutdownEvent(thermalShutdownEvent),
        .ledModeDetect(ledModeDetect), .protectionEvent(protectionEvent),
        .battTempRatioSelect(battTempRatioSelect), .stepDownFiveEnable(stepDownFiveEnable),
        .ldoSixEnable(ldoSixEnable), .ldoEightEnable(ldoEightEnable),
        .whiteLedDriverOn(whiteLedDriverOn), .ledFeedbackReference(ledFeedbackReference));
    pse_i2c_host i_host (.core_clk(core_clk), .sdaWire(sdaIn), .sclOut(hostScl),
        .sdaLow(hostSdaLow));
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 80000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic [7:0] exp_ctrl(input logic therm, input logic mode,
        input logic ratio);
        logic [7:0] r;
        r = 8'h00;
        r[PSE_BIT_THERM] = therm;
        r[PSE_BIT_MODE] = mode;
        r[PSE_BIT_RATIO] = ratio;
        return r;
    endfunction
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic a;
        i_host.write_reg(PSE_DEV_ADDR, ofs, d, a);
        `CHK(a, 1'b1)
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        i_host.read_reg(PSE_DEV_ADDR, ofs, d, a);
        `CHK(a, 1'b1)
        `CHK(d, exp)
    endtask
    task automatic chk_chan(input logic [7:0] e);
        `CHK(stepDownFiveEnable, e[PSE_BIT_STEP5])
        `CHK(ldoSixEnable, e[PSE_BIT_LDO6])
        `CHK(ldoEightEnable, e[PSE_BIT_LDO8])
        `CHK(whiteLedDriverOn, (e[4:0] != 5'h00))
        `CHK(ledFeedbackReference, e[PSE_CODE_MSB:0])
    endtask
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask
    initial
    begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        powerOnDone = 1'b0;
        thermalShutdownEvent = 1'b0;
        ledModeDetect = 1'b0;
        protectionEvent = 8'h00;
        seedTmp = $urandom(32'h548d77be);
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        settle();
        `CHK(battTempRatioSelect, 1'b1)
        `CHK(sdaOut, 1'b0)
        `CHK(sdaOe, 1'b0)
        chk_chan(8'h00);
        // Bus must stay deaf until power-on completes
        i_host.write_reg(PSE_DEV_ADDR, PSE_OFS_CHAN, 8'hff, ok);
        `CHK(ok, 1'b0)
        chk_chan(8'h00);
        powerOnDone = 1'b1;
        rd_chk(PSE_OFS_PROT, 8'h00);
        rd_chk(PSE_OFS_CHAN, 8'h00);
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b0, 1'b0, 1'b1));
        rd_chk(8'h10, PSE_RD_UNMAPPED);
        $display("test reset and gating done");
        for (int i = 0; i < 12; i++)
        begin
            v = (i < 8) ? corner[i] : 8'($urandom());
            wr(PSE_OFS_CHAN, v);
            chk_chan(v);
            rd_chk(PSE_OFS_CHAN, v);
        end
        v = 8'($urandom());
        i_host.write_pair(PSE_DEV_ADDR, PSE_OFS_PROT, 8'h00, v, ok);
        `CHK(ok, 1'b1)
        chk_chan(v);
        i_host.read_pair(PSE_DEV_ADDR, PSE_OFS_PROT, p, c, ok);
        `CHK(ok, 1'b1)
        `CHK(p, 8'h00)
        `CHK(c, v)
        $display("test channel enables done");
        ledModeDetect = 1'b1;
        settle();
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b0, 1'b1, 1'b1));
        wr(PSE_OFS_CTRL, 8'h00);
        `CHK(battTempRatioSelect, 1'b0)
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b0, 1'b1, 1'b0));
        ledModeDetect = 1'b0;
        wr(PSE_OFS_CTRL, 8'hff);
        `CHK(battTempRatioSelect, 1'b1)
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b0, 1'b0, 1'b1));
        thermalShutdownEvent = 1'b1;
        settle();
        thermalShutdownEvent = 1'b0;
        settle();
        wr(PSE_OFS_CTRL, 8'h05);
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b1, 1'b0, 1'b1));
        thermalShutdownEvent = 1'b1;
        wr(PSE_OFS_CTRL, 8'h01);
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b1, 1'b0, 1'b1));
        thermalShutdownEvent = 1'b0;
        settle();
        wr(PSE_OFS_CTRL, 8'h01);
        rd_chk(PSE_OFS_CTRL, exp_ctrl(1'b0, 1'b0, 1'b1));
        $display("test control status done");
        // Faster host for the flag traffic
        i_host.halfCycles = 5;
        for (int i = 0; i < 5; i++)
        begin
            p = (i == 0) ? 8'h81 : 8'($urandom());
            c = 8'($urandom());
            protectionEvent = p;
            settle();
            protectionEvent = 8'h00;
            settle();
            rd_chk(PSE_OFS_PROT, p);
            wr(PSE_OFS_PROT, c);
            rd_chk(PSE_OFS_PROT, p & c);
            wr(PSE_OFS_PROT, 8'h00);
            rd_chk(PSE_OFS_PROT, 8'h00);
        end
        protectionEvent = 8'h10;
        wr(PSE_OFS_PROT, 8'h00);
        rd_chk(PSE_OFS_PROT, 8'h10);
        protectionEvent = 8'h00;
        settle();
        wr(PSE_OFS_PROT, 8'h00);
        rd_chk(PSE_OFS_PROT, 8'h00);
        $display("test protection flags done");
        report_and_stop();
    end
endmodule
